//--- logic/pfr_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "pfr_consts.vh"
module pfr_regs (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Register access, word data in bus order, bit 0 is the msb
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    output reg reg_ack,
    // Mode settings from neighbouring registers
    input wire settings_changed,
    input wire combo_bad,
    input wire coding_10bit,
    input wire [31:0] frame_bytes,
    input wire [15:0] rec_pkt_bytes,
    input wire [31:0] period_float,
    // Towards the packet transmitter and capture control
    output reg [15:0] pkt_bytes,
    output reg [31:0] pkts_per_frame,
    output reg capture_allowed,
    output reg calc_busy
);
    reg [15:0] pkt_q;
    reg [15:0] rec_q;
    reg [31:0] period_q;
    reg [7:0] depth_q;
    reg combo_bad_q;
    reg pkt_bad_q;
    reg recalc_q;
    reg calc_done_q;
    reg [31:0] rdata_d;
    reg pkt_bad_d;
    wire pkt_wr;
    wire busy;
    wire [31:0] count;

    assign pkt_wr = reg_wr && (reg_addr == `PFR_OFS_PKT_SIZE);

    // Packet size check covers zero, step and upper limit
    always @* begin
        pkt_bad_d = (reg_wdata[31:16] == 16'h0000) ||
                    ((reg_wdata[31:16] & `PFR_PKT_UNIT_MASK) != 16'h0000) ||
                    (reg_wdata[31:16] > `PFR_PKT_MAX);
    end

    pfr_pkt_calc u_calc (
        .mclk(mclk),
        .rst(rst),
        .start(recalc_q),
        .frame_bytes(frame_bytes),
        .pkt_bytes(pkt_q),
        .busy(busy),
        .count(count)
    );

    always @(posedge mclk) begin
        if (rst) begin
            pkt_q <= `PFR_PKT_RESET;
            rec_q <= 16'h0000;
            period_q <= 32'h00000000;
            depth_q <= `PFR_DEPTH_8;
            combo_bad_q <= 1'b0;
            pkt_bad_q <= 1'b0;
            recalc_q <= 1'b1;
            calc_done_q <= 1'b0;
            pkts_per_frame <= 32'h00000000;
        end else begin
            // Bits 0 to 15 in msb-first order are word bits 31:16
            if (pkt_wr) begin
                pkt_q <= reg_wdata[31:16];
                pkt_bad_q <= pkt_bad_d;
            end
            if (settings_changed || pkt_wr) begin
                rec_q <= rec_pkt_bytes;
                period_q <= period_float;
                depth_q <= coding_10bit ? `PFR_DEPTH_10 : `PFR_DEPTH_8;
                combo_bad_q <= combo_bad;
            end
            recalc_q <= settings_changed || pkt_wr;
            calc_done_q <= busy;
            // Publish only when the divider has settled
            if (calc_done_q && !busy) begin
                pkts_per_frame <= count;
            end
        end
    end

    always @* begin
        rdata_d = 32'h00000000;
        case (reg_addr)
            `PFR_OFS_PKT_SIZE: rdata_d = {pkt_q, rec_q};
            `PFR_OFS_PKT_COUNT: rdata_d = pkts_per_frame;
            `PFR_OFS_POS_STEP: rdata_d = {`PFR_COL_STEP, `PFR_ROW_STEP};
            `PFR_OFS_PERIOD: rdata_d = period_q;
            `PFR_OFS_DEPTH: rdata_d = {depth_q, 24'h000000};
            // Bit 0 is word bit 31, bit 8 is 23, bit 9 is 22; bit 1 reads 0
            `PFR_OFS_VALID: rdata_d = {1'b1, 7'h00, combo_bad_q, pkt_bad_q,
                                       22'h000000};
            default: rdata_d = 32'h00000000;
        endcase
    end

    always @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
            reg_ack <= 1'b0;
            pkt_bytes <= `PFR_PKT_RESET;
            capture_allowed <= 1'b0;
            calc_busy <= 1'b0;
        end else begin
            reg_ack <= reg_rd || reg_wr;
            if (reg_rd) begin
                reg_rdata <= rdata_d;
            end
            pkt_bytes <= pkt_q;
            // Also blocked while packet count is stale or over the limit
            capture_allowed <= !combo_bad_q && !pkt_bad_q && !busy && !recalc_q &&
                               !calc_done_q &&
                               (pkts_per_frame <= `PFR_PKTS_MAX);
            calc_busy <= busy || recalc_q || calc_done_q;
        end
    end
endmodule // pfr_regs
`default_nettype wire

//--- include/pfr_consts.vh
`ifndef PFR_CONSTS_VH
`define PFR_CONSTS_VH
// Byte offsets from the mode base address
`define PFR_OFS_PKT_SIZE 8'h44
`define PFR_OFS_PKT_COUNT 8'h48
`define PFR_OFS_POS_STEP 8'h4C
`define PFR_OFS_PERIOD 8'h50
`define PFR_OFS_DEPTH 8'h54
`define PFR_OFS_VALID 8'h7C
// Fixed inquiry values
`define PFR_COL_STEP 16'h0004
`define PFR_ROW_STEP 16'h0001
`define PFR_DEPTH_8 8'h08
`define PFR_DEPTH_10 8'h0A
// Packet size and packets-per-frame limits
`define PFR_PKT_MAX 16'h1000
`define PFR_PKT_UNIT_MASK 16'h0003
`define PFR_PKTS_MAX 32'h00000FFF
// Reset value of the packet size setting
`define PFR_PKT_RESET 16'h1000
`endif

//--- logic/pfr_pkt_calc.v
`timescale 1ns/1ps
`default_nettype none
// Packets per frame by iterative subtraction; one cycle per packet
module pfr_pkt_calc (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Request
    input wire start,
    input wire [31:0] frame_bytes,
    input wire [15:0] pkt_bytes,
    // Result
    output reg busy,
    output reg [31:0] count
);
    reg [31:0] rem_q;

    always @(posedge mclk) begin
        if (rst) begin
            busy <= 1'b0;
            count <= 32'h00000000;
            rem_q <= 32'h00000000;
        end else if (start) begin
            busy <= (pkt_bytes != 16'h0000);
            count <= 32'h00000000;
            rem_q <= frame_bytes;
        end else if (busy) begin
            // Runs one cycle per packet, frame_bytes / pkt_bytes rounded up, with no fixed upper bound
            if (rem_q == 32'h00000000) begin
                busy <= 1'b0;
            end else if (rem_q <= {16'h0000, pkt_bytes}) begin
                rem_q <= 32'h00000000;
                count <= count + 32'h00000001;
                busy <= 1'b0;
            end else begin
                rem_q <= rem_q - {16'h0000, pkt_bytes};
                count <= count + 32'h00000001;
            end
        end
    end
endmodule // pfr_pkt_calc
`default_nettype wire

//--- tb/pfr_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pfr_regs_chk (
    // Clock, reset and access
    input wire logic mclk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_ack,
    // Status
    input wire logic [15:0] pkt_bytes,
    input wire logic [31:0] pkts_per_frame,
    input wire logic capture_allowed,
    input wire logic calc_busy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_rd(logic [7:0] ad);
        reg_rd && reg_addr == ad;
    endsequence
    sequence s_pkt_wr;
        reg_wr && reg_addr == 8'h44;
    endsequence
    a_ack_follows: assert property ((reg_rd || reg_wr) |=> reg_ack) else $error("ack missing");
    a_ack_idle: assert property (!(reg_rd || reg_wr) |=> !reg_ack) else $error("stray ack");
    a_pos_step: assert property (s_rd(8'h4C) |=> reg_rdata == 32'h00040001)
        else $error("bad position step");
    a_valid_fixed: assert property (s_rd(8'h7C) |=> reg_rdata[31:30] == 2'h2)
        else $error("bad validity head");
    a_valid_resvd: assert property (s_rd(8'h7C) |=> reg_rdata[29:24] == 6'h0)
        else $error("validity reserved set");
    a_depth_code: assert property (s_rd(8'h54) |=> reg_rdata[23:0] == 24'h0 &&
        reg_rdata[31:24] inside {8'h08, 8'h0A}) else $error("bad depth word");
    // Two cycles: stored at ack, visible on the next edge
    a_pkt_store: assert property (s_pkt_wr ##1 1'b1 |=> {pkt_bytes, 16'h0} ==
        ($past(reg_wdata, 2) & 32'hFFFF0000)) else $error("packet size not taken");
    a_busy_block: assert property (calc_busy [*2] |-> !capture_allowed)
        else $error("capture while recomputing");
    a_count_limit: assert property (capture_allowed |-> pkts_per_frame <= 32'h00000FFF)
        else $error("capture with too many packets");
endmodule // pfr_regs_chk
bind pfr_regs pfr_regs_chk i_chk (.*);
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk = 0, rst = 1, wr = 0, rd = 0, sc = 0, cb = 0, c10 = 0, ack, cap, busy;
    logic [7:0] a = 8'h0;
    logic [31:0] wd = 32'h0, fb = 32'h8000, per = 32'h3D000000, rdat, ppf;
    logic [15:0] rec = 16'h0200, pkt;
    int n_fail = 0, compares = 0, i;
    pfr_regs i_pfr_regs (.mclk(mclk), .rst(rst), .reg_wr(wr), .reg_rd(rd), .reg_addr(a),
        .reg_wdata(wd), .reg_rdata(rdat), .reg_ack(ack), .settings_changed(sc),
        .combo_bad(cb), .coding_10bit(c10), .frame_bytes(fb), .rec_pkt_bytes(rec),
        .period_float(per), .pkt_bytes(pkt), .pkts_per_frame(ppf),
        .capture_allowed(cap), .calc_busy(busy));
    initial forever #2 mclk = ~mclk;
    task chk(input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task end_of_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Request held until the edge that raises ack
    task acc(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge mclk) #1;
        wr = w;
        rd = !w;
        a = ad;
        wd = d;
        @(posedge mclk) #1;
        wr = 0;
        rd = 0;
    endtask
    task rdc(input logic [7:0] ad, input logic [31:0] e);
        acc(0, ad, 32'h0);
        chk(rdat, e);
    endtask
    task upd;
        @(posedge mclk) #1;
        sc = 1;
        @(posedge mclk) #1;
        sc = 0;
    endtask
    task calc;
        repeat (3) @(posedge mclk);
        // Long enough for a count just over the 4095 packet limit
        for (i = 0; i < 5000 && busy !== 0; i++) @(posedge mclk);
        repeat (2) @(posedge mclk);
        chk(busy, 32'h0);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        #1 rst = 0;
        chk(pkt, 16'h1000);
        upd;
        calc;
        rdc(8'h4C, 32'h00040001);
        rdc(8'h54, 32'h08000000);
        rdc(8'h50, per);
        rdc(8'h44, 32'h10000200);
        rdc(8'h48, 32'h8);
        c10 = 1;
        per = 32'h3E000000;
        rec = 16'h0400;
        upd;
        rdc(8'h54, 32'h0A000000);
        rdc(8'h50, per);
        rdc(8'h44, 32'h10000400);
        acc(1, 8'h44, 32'h0800FFFF);
        calc;
        rdc(8'h48, 32'h10);
        chk(ppf, 32'h10);
        chk(pkt, 32'h0800);
        rdc(8'h44, 32'h08000400);
        chk(cap, 32'h1);
        rdc(8'h7C, 32'h80000000);
        acc(1, 8'h44, 32'h08020000);
        calc;
        rdc(8'h7C, 32'h80400000);
        chk(cap, 32'h0);
        // Smallest legal size gives 4096 packets, one over the limit
        fb = 32'h4000;
        acc(1, 8'h44, 32'h00040000);
        calc;
        chk(ppf, 32'h1000);
        rdc(8'h7C, 32'h80000000);
        chk(cap, 32'h0);
        acc(1, 8'h44, 32'h08000000);
        cb = 1;
        upd;
        calc;
        rdc(8'h7C, 32'h80800000);
        chk(cap, 32'h0);
        acc(1, 8'h4C, 32'hFFFFFFFF);
        rdc(8'h4C, 32'h00040001);
        rdc(8'h60, 32'h0);
        end_of_test;
    end
    initial begin
        #100000;
        n_fail++;
        end_of_test;
    end
endmodule // tb
`default_nettype wire
